// file: rtl/pric_params.svh
`ifndef PRIC_PARAMS_SVH
`define PRIC_PARAMS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PRIC_OFS_CTRL_ONE   8'h00
`define PRIC_OFS_CTRL_TWO   8'h04
`define PRIC_OFS_CTRL_THREE 8'h08
`define PRIC_OFS_CTRL_FOUR  8'h0C
`define PRIC_OFS_FLAG       8'h10
`define PRIC_OFS_ENABLE     8'h14
`define PRIC_OFS_PRIO0      8'h18
`define PRIC_OFS_PRIO1      8'h1C
`define PRIC_OFS_PENDING    8'h20
`define PRIC_OFS_STATUS     8'h24
`define PRIC_OFS_CORCTL     8'h28
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define PRIC_BIT_NEST_DIS   15
`define PRIC_BIT_GIE        15
`define PRIC_BIT_SOFT_SET   16
`define PRIC_BIT_TOP_LEVEL  3
`define PRIC_NUM_TRAP       9
`define PRIC_TRAP_SOFT      8
`define PRIC_TRAP_LEVEL     4'hF
`define PRIC_NEST_LEVEL     4'h7
`define PRIC_USER_VEC_BASE  8'h08
`define PRIC_RESET_ADDR     24'h000000
`endif

// file: rtl/pric_pkg.sv
package pric_pkg;
	typedef logic [3:0]  pric_level_t;
	typedef logic [7:0]  pric_vec_t;
	typedef logic [31:0] pric_word_t;
endpackage

// file: rtl/pric_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pric_params.svh"
// Behaviour
// - Reset clears every register but ext_prev (follows the pin) and avs_waitrequest (set), holds the fetch address at zero and restarts the core there.
// - Reset is no exception: the controller raises no request and no vector for it.
// - The first global control register holds nesting disable and the core trap flags.
// - The second holds the external input edge selects and the global user enable.
// - The third holds the deadman-timer, DMA and loop-stack-overflow trap flags.
// - The fourth holds the double-bit-error flag and the software hard trap flag.
// - Each source has one flag that hardware sets and software clears.
// - Each source has its own enable bit.
// - Each user source has a writable three-bit priority of eight levels.
// - The pending vector and its priority as the new level are latched into a readable register.
// - Flags, enables and priorities are laid out in vector order, first external input at bit 0.
// - Status bits 7:5 show the current level and software may write them.
// - The top level bit sits in core control and is read-only to software.
module pric_ctrl #(
	parameter int NUM_SRC = 16,
	parameter int NUM_EXT = 3
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic [NUM_EXT-1:0] ext_irq,
	input  wire logic [NUM_SRC-1:0] src_evt,
	input  wire logic [7:0]        trap_evt,
	input  wire logic              irq_ack,
	input  wire logic              irq_ret,
	input  wire pric_pkg::pric_level_t ret_level,
	output logic                   irq_req,
	output pric_pkg::pric_vec_t    irq_vector,
	output pric_pkg::pric_level_t  irq_level,
	output logic                   int_out,
	output logic                   core_restart,
	output logic [23:0]            core_start_addr
);
	import pric_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic                     nest_dis;
	logic                     global_irq_enable;
	logic [NUM_EXT-1:0]       ext_fall;
	logic [NUM_EXT-1:0]       ext_prev;
	logic [`PRIC_NUM_TRAP-1:0] trap_flag;
	logic [NUM_SRC-1:0]       flag;
	logic [NUM_SRC-1:0]       enable;
	logic [2:0]               prio [NUM_SRC];
	pric_level_t              cpu_level;
	pric_vec_t                pend_vec;
	pric_level_t              pend_lvl;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        acc_req  = (avs_read | avs_write) & avs_waitrequest;
	wire        wr_fire  = avs_write & ~avs_waitrequest;
	wire [31:0] wd       = avs_writedata;
	wire        wr_one   = wr_fire && avs_address == `PRIC_OFS_CTRL_ONE;
	wire        wr_two   = wr_fire && avs_address == `PRIC_OFS_CTRL_TWO;
	wire        wr_three = wr_fire && avs_address == `PRIC_OFS_CTRL_THREE;
	wire        wr_four  = wr_fire && avs_address == `PRIC_OFS_CTRL_FOUR;
	wire        wr_flag  = wr_fire && avs_address == `PRIC_OFS_FLAG;
	wire        wr_en    = wr_fire && avs_address == `PRIC_OFS_ENABLE;
	wire        wr_pr0   = wr_fire && avs_address == `PRIC_OFS_PRIO0;
	wire        wr_pr1   = wr_fire && avs_address == `PRIC_OFS_PRIO1;
	wire        wr_stat  = wr_fire && avs_address == `PRIC_OFS_STATUS;

	// Trap clear mask, one-to-clear, gathered from three registers
	wire [`PRIC_NUM_TRAP-1:0] trap_clr = {
		wr_four & wd[1], wr_four & wd[0],
		wr_three & wd[2], wr_three & wd[1], wr_three & wd[0],
		wr_one & wd[3], wr_one & wd[2], wr_one & wd[1], wr_one & wd[0]};
	wire soft_set = wr_four & wd[`PRIC_BIT_SOFT_SET];
	wire [`PRIC_NUM_TRAP-1:0] trap_set = {soft_set, trap_evt};

	// Edge select per external input: 0 rising, 1 falling
	wire [NUM_EXT-1:0] ext_edge = ((ext_prev & ~ext_irq) & ext_fall)
		| ((~ext_prev & ext_irq) & ~ext_fall);
	wire [NUM_SRC-1:0] src_set = src_evt | NUM_SRC'(ext_edge);

	function automatic pric_word_t prio_word(input int w);
		pric_word_t r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			if (w * 8 + i < NUM_SRC) begin
				r[i*4 +: 3] = prio[w*8 + i];
			end
		end
		return r;
	endfunction

	pric_word_t rd_mux;
	always_comb begin
		unique case (avs_address)
			`PRIC_OFS_CTRL_ONE:   rd_mux = {16'h0000, nest_dis, 11'h000, trap_flag[3:0]};
			`PRIC_OFS_CTRL_TWO:   rd_mux = {16'h0000, global_irq_enable, 15'(ext_fall)};
			`PRIC_OFS_CTRL_THREE: rd_mux = {29'h0, trap_flag[6:4]};
			`PRIC_OFS_CTRL_FOUR:  rd_mux = {30'h0, trap_flag[8:7]};
			`PRIC_OFS_FLAG:       rd_mux = 32'(flag);
			`PRIC_OFS_ENABLE:     rd_mux = 32'(enable);
			`PRIC_OFS_PRIO0:      rd_mux = prio_word(0);
			`PRIC_OFS_PRIO1:      rd_mux = prio_word(1);
			`PRIC_OFS_PENDING:    rd_mux = {20'h00000, pend_lvl, pend_vec};
			`PRIC_OFS_STATUS:     rd_mux = {24'h000000, cpu_level[2:0], 5'h00};
			`PRIC_OFS_CORCTL:     rd_mux = {28'h0000000, cpu_level[3], 3'h0};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	wire [NUM_SRC-1:0] user_act = flag & enable & {NUM_SRC{global_irq_enable}};
	logic       u_ok;
	logic [2:0] u_prio;
	logic [7:0] u_idx;
	always_comb begin
		u_ok   = 1'b0;
		u_prio = 3'h0;
		u_idx  = 8'h00;
		for (int k = 0; k < NUM_SRC; k++) begin
			// Strict compare keeps the lower index on a tie
			if (user_act[k] && (!u_ok || prio[k] > u_prio)) begin
				u_ok   = 1'b1;
				u_prio = prio[k];
				u_idx  = 8'(k);
			end
		end
	end
	logic [7:0] t_idx;
	always_comb begin
		t_idx = 8'h00;
		for (int t = `PRIC_NUM_TRAP - 1; t >= 0; t--) begin
			if (trap_flag[t]) begin
				t_idx = 8'(t);
			end
		end
	end
	// Traps ignore enables and gie
	wire        t_go   = |trap_flag && `PRIC_TRAP_LEVEL > cpu_level;
	wire        u_go   = u_ok && {1'b0, u_prio} > cpu_level;
	wire        any_go = t_go | u_go;
	// Last two traps share the top trap vector
	wire [7:0]  t_vec  = (t_idx > 8'h07) ? 8'h07 : t_idx;
	wire [7:0]  next_vec = t_go ? t_vec : 8'(`PRIC_USER_VEC_BASE + u_idx);
	wire [3:0]  next_lvl = t_go ? `PRIC_TRAP_LEVEL : {1'b0, u_prio};
	// Nesting disabled lifts user service to the top user level
	wire [3:0]  ack_lvl  = (nest_dis && !irq_level[3]) ? `PRIC_NEST_LEVEL : irq_level;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			// One wait state: data are ready the cycle waitrequest drops
			avs_waitrequest <= ~acc_req;
			avs_readdata    <= acc_req ? rd_mux : avs_readdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nest_dis  <= 1'b0;
			global_irq_enable       <= 1'b0;
			ext_fall  <= '0;
			ext_prev  <= ext_irq; // Follow the pin so release brings no false edge
			trap_flag <= '0;
			flag      <= '0;
			enable    <= '0;
		end else begin
			nest_dis  <= wr_one ? wd[`PRIC_BIT_NEST_DIS] : nest_dis;
			global_irq_enable       <= wr_two ? wd[`PRIC_BIT_GIE] : global_irq_enable;
			ext_fall  <= wr_two ? wd[NUM_EXT-1:0] : ext_fall;
			ext_prev  <= ext_irq;
			// Set beats clear
			trap_flag <= (trap_flag & ~trap_clr) | trap_set;
			flag      <= (flag & ~(wr_flag ? wd[NUM_SRC-1:0] : '0)) | src_set;
			enable    <= wr_en ? wd[NUM_SRC-1:0] : enable;
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int k = 0; k < NUM_SRC; k++) begin
			if (sys_rst) begin
				prio[k] <= 3'h0;
			end else if ((k < 8 && wr_pr0) || (k >= 8 && wr_pr1)) begin
				prio[k] <= wd[(k%8)*4 +: 3];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cpu_level <= 4'h0;
			pend_vec  <= 8'h00;
			pend_lvl  <= 4'h0;
			irq_req   <= 1'b0;
			irq_vector <= 8'h00;
			irq_level <= 4'h0;
			int_out   <= 1'b0;
		end else begin
			if (irq_ack && irq_req) begin
				cpu_level <= ack_lvl;
			end else if (irq_ret) begin
				cpu_level <= ret_level;
			end else if (wr_stat) begin
				cpu_level <= {cpu_level[3], wd[7:5]};
			end
			if (any_go) begin
				pend_vec <= next_vec;
				pend_lvl <= next_lvl;
			end
			irq_req    <= any_go;
			irq_vector <= any_go ? next_vec : irq_vector;
			irq_level  <= any_go ? next_lvl : irq_level;
			int_out    <= |(flag & enable) | |trap_flag;
		end
	end

	always_ff @(posedge clk_sys) begin
		core_restart    <= sys_rst;
		core_start_addr <= `PRIC_RESET_ADDR;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_evt_and_clear;
		src_evt[0] && wr_flag && wd[0];
	endsequence
	sequence s_req_seen;
		acc_req ##1 !avs_waitrequest;
	endsequence
	property p_set_wins;
		@(posedge clk_sys) disable iff (sys_rst) s_evt_and_clear |=> flag[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost");
	property p_clear;
		@(posedge clk_sys) disable iff (sys_rst)
			wr_flag && wd[0] && !src_set[0] |=> !flag[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_enable_gate;
		@(posedge clk_sys) disable iff (sys_rst)
			!t_go && !(|(flag & enable)) |=> !irq_req;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("disabled req");
	property p_level_gate;
		@(posedge clk_sys) disable iff (sys_rst)
			irq_req && !irq_level[3] |-> irq_level > $past(cpu_level);
	endproperty
	a_level_gate: assert property (p_level_gate) else $error("level not above");
	property p_trap_top;
		@(posedge clk_sys) disable iff (sys_rst)
			t_go |=> irq_req && irq_level == `PRIC_TRAP_LEVEL && irq_vector < 8'h08;
	endproperty
	a_trap_top: assert property (p_trap_top) else $error("trap not on top");
	property p_pend_match;
		@(posedge clk_sys) disable iff (sys_rst)
			irq_req |-> pend_vec == irq_vector && pend_lvl == irq_level;
	endproperty
	a_pend_match: assert property (p_pend_match) else $error("pending mismatch");
	property p_top_ro;
		@(posedge clk_sys) disable iff (sys_rst)
			wr_stat && !irq_ack && !irq_ret |=> cpu_level == {$past(cpu_level[3]), $past(wd[7:5])};
	endproperty
	a_top_ro: assert property (p_top_ro) else $error("level write wrong");
	property p_bus_one_wait;
		@(posedge clk_sys) disable iff (sys_rst) s_req_seen |-> avs_readdata == $past(rd_mux);
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait) else $error("bad read data");
	property p_reset_quiet;
		@(posedge clk_sys) sys_rst |=> !irq_req && pend_vec == 8'h00 && core_restart;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset vector");
	property p_nest_level;
		@(posedge clk_sys) disable iff (sys_rst)
			irq_ack && irq_req && nest_dis && !irq_level[3] |=> cpu_level == `PRIC_NEST_LEVEL;
	endproperty
	a_nest_level: assert property (p_nest_level) else $error("nest level wrong");
	property p_ret_level;
		@(posedge clk_sys) disable iff (sys_rst)
			irq_ret && !(irq_ack && irq_req) |=> cpu_level == $past(ret_level);
	endproperty
	a_ret_level: assert property (p_ret_level) else $error("return level wrong");
	property p_ext_rise;
		@(posedge clk_sys) disable iff (sys_rst)
			!ext_fall[0] && !ext_prev[0] && ext_irq[0] |=> flag[0];
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("edge lost");
	property p_int_out;
		@(posedge clk_sys) disable iff (sys_rst)
			(|(flag & enable)) || (|trap_flag) |=> int_out;
	endproperty
	a_int_out: assert property (p_int_out) else $error("interrupt low");
endmodule
`default_nettype wire

// file: tb/pric_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pric_core_model (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              irq_req,
	input  wire pric_pkg::pric_vec_t irq_vector,
	input  wire logic              ack_en,
	input  wire logic              ret_go,
	output logic                   irq_ack,
	output logic                   irq_ret,
	output pric_pkg::pric_level_t  ret_level,
	output pric_pkg::pric_vec_t    last_vec
);
	import pric_pkg::*;
	logic busy;
	// One ack per request; a stale irq_req must not be taken twice
	always_ff @(posedge clk_sys) begin
		irq_ack <= 1'b0;
		irq_ret <= 1'b0;
		if (sys_rst) begin
			busy <= 1'b0;
			last_vec <= 8'h00;
		end else if (ack_en && irq_req && !busy) begin
			irq_ack <= 1'b1;
			busy <= 1'b1;
			last_vec <= irq_vector;
		end else if (busy && ret_go) begin
			irq_ret <= 1'b1;
			busy <= 1'b0;
		end
	end
	assign ret_level = 4'h0;
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pric_params.svh"
module testbench;
	import pric_pkg::*;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  ext_irq = 3'h0;
	logic [15:0] src_evt = 16'h0;
	logic [7:0]  trap_evt = 8'h00;
	logic        irq_ack, irq_ret, irq_req, int_out, core_restart;
	logic        ack_en = 1'b0;
	logic        ret_go = 1'b0;
	pric_level_t ret_level, irq_level;
	pric_vec_t   irq_vector, last_vec;
	logic [23:0] core_start_addr;
	logic [31:0] q;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          seed = 32'h46fc;
	int          prio[16];
	always #2.5 clk_sys = ~clk_sys;
	pric_ctrl i_pric_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq(ext_irq),
		.src_evt(src_evt), .trap_evt(trap_evt), .irq_ack(irq_ack), .irq_ret(irq_ret),
		.ret_level(ret_level), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .int_out(int_out), .core_restart(core_restart),
		.core_start_addr(core_start_addr));
	pric_core_model i_pric_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.irq_req(irq_req), .irq_vector(irq_vector), .ack_en(ack_en), .ret_go(ret_go),
		.irq_ack(irq_ack), .irq_ret(irq_ret), .ret_level(ret_level), .last_vec(last_vec));
	// ----
	// Bus and compare helpers
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			results();
		end
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Two extra edges so registered outputs have settled for the caller
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic pulse_src(input logic [15:0] m);
		src_evt <= m;
		@(posedge clk_sys);
		src_evt <= 16'h0;
		repeat (3) @(posedge clk_sys);
	endtask
	// Reference arbiter: highest level above the core, lowest index on ties
	function automatic int win(input logic [15:0] f, input int l);
		win = -1;
		for (int k = 0; k < 16; k++)
			if (f[k] && prio[k] > l && (win < 0 || prio[k] > prio[win])) win = k;
	endfunction
	task results;
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		results();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (3) @(posedge clk_sys);
		chk("core_restart", core_restart, 1);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk("core_start_addr", core_start_addr, 0);
		chk("irq_req", irq_req, 0);
		for (int a = 0; a < 'h2C; a += 4) begin
			rd(8'(a));
			chk("reset reg", q, 0);
		end
		rd(8'h40);
		chk("unmapped", q, 0);
		for (int i = 0; i < 8; i++) begin
			logic [7:0] a;
			int b;
			a = i < 4 ? `PRIC_OFS_CTRL_ONE : i < 7 ? `PRIC_OFS_CTRL_THREE : `PRIC_OFS_CTRL_FOUR;
			b = i < 4 ? i : i < 7 ? i - 4 : 0;
			trap_evt <= 8'(1 << i);
			@(posedge clk_sys);
			trap_evt <= 8'h00;
			repeat (3) @(posedge clk_sys);
			chk("trap req", {irq_req, int_out}, 2'b11);
			chk("trap vector", irq_vector, i);
			chk("trap level", irq_level, `PRIC_TRAP_LEVEL);
			rd(a);
			chk("trap flag", q[b], 1);
			wr(a, 32'h1 << b);
			rd(a);
			chk("trap clear", q[b], 0);
		end
		wr(`PRIC_OFS_CTRL_FOUR, 32'h1 << `PRIC_BIT_SOFT_SET);
		rd(`PRIC_OFS_CTRL_FOUR);
		chk("soft trap", q[1], 1);
		chk("soft vector", irq_vector, 7);
		wr(`PRIC_OFS_CTRL_FOUR, 32'h2);
		wr(`PRIC_OFS_CTRL_TWO, 32'h2);
		ext_irq <= 3'b011;
		repeat (3) @(posedge clk_sys);
		rd(`PRIC_OFS_FLAG);
		chk("ext rise", q, 32'h1);
		ext_irq <= 3'b000;
		repeat (3) @(posedge clk_sys);
		rd(`PRIC_OFS_FLAG);
		chk("ext fall", q, 32'h3);
		wr(`PRIC_OFS_PRIO0, 32'h7);
		wr(`PRIC_OFS_ENABLE, 32'h3);
		chk("gie off", {irq_req, int_out}, 2'b01);
		wr(`PRIC_OFS_CTRL_TWO, 32'h1 << `PRIC_BIT_GIE);
		chk("gie on", irq_req, 1);
		wr(`PRIC_OFS_FLAG, 32'hFFFF);
		rd(`PRIC_OFS_FLAG);
		chk("flag clear", q, 0);
		src_evt <= 16'h1;
		wr(`PRIC_OFS_FLAG, 32'h1);
		src_evt <= 16'h0;
		rd(`PRIC_OFS_FLAG);
		chk("set wins", q[0], 1);
		wr(`PRIC_OFS_FLAG, 32'hFFFF);
		wr(`PRIC_OFS_CORCTL, 32'h8);
		rd(`PRIC_OFS_CORCTL);
		chk("top level bit", q[3], 0);
		repeat (12) begin
			int k0, k1, l, w;
			logic [15:0] en, f;
			logic [31:0] pw;
			for (int k = 0; k < 16; k++) prio[k] = $unsigned($random(seed)) % 8;
			k0 = $unsigned($random(seed)) % 16;
			k1 = $unsigned($random(seed)) % 16;
			if ($random(seed) & 1) prio[k1] = prio[k0];
			l = $unsigned($random(seed)) % 4;
			en = 16'($random(seed)) | 16'(1 << k1);
			f = 16'(1 << k0) | 16'(1 << k1);
			for (int j = 0; j < 2; j++) begin
				for (int k = 0; k < 8; k++) pw[k*4+:4] = 4'(prio[j*8+k] & 7);
				wr(`PRIC_OFS_PRIO0 + 8'(j * 4), pw);
			end
			wr(`PRIC_OFS_STATUS, 32'(l << 5));
			wr(`PRIC_OFS_ENABLE, 32'(en));
			pulse_src(f);
			w = win(f & en, l);
			chk("irq_req", irq_req, w >= 0);
			chk("int_out", int_out, |(f & en));
			rd(`PRIC_OFS_STATUS);
			chk("cpu level", q[7:5], l);
			if (w >= 0) begin
				rd(`PRIC_OFS_PENDING);
				chk("pending", q[11:0], prio[w] * 256 + 8 + w);
				chk("irq_vector", irq_vector, 8 + w);
			end
			wr(`PRIC_OFS_FLAG, 32'hFFFF);
		end
		wr(`PRIC_OFS_STATUS, 32'h0);
		wr(`PRIC_OFS_PRIO0, 32'h500);
		wr(`PRIC_OFS_ENABLE, 32'h4);
		ack_en <= 1'b1;
		pulse_src(16'h4);
		repeat (3) @(posedge clk_sys);
		chk("acked vector", last_vec, 8'h0A);
		chk("req after ack", irq_req, 0);
		rd(`PRIC_OFS_STATUS);
		chk("level after ack", q[7:5], 5);
		wr(`PRIC_OFS_FLAG, 32'h4);
		ret_go <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ret_go <= 1'b0;
		rd(`PRIC_OFS_STATUS);
		chk("level after return", q[7:5], 0);
		wr(`PRIC_OFS_CTRL_ONE, 32'h1 << `PRIC_BIT_NEST_DIS);
		rd(`PRIC_OFS_CTRL_ONE);
		chk("nest disable", q[15], 1);
		pulse_src(16'h4);
		repeat (3) @(posedge clk_sys);
		rd(`PRIC_OFS_STATUS);
		chk("nested level", q[7:5], 7);
		results();
	end
endmodule
`default_nettype wire
